/* verilog/spim_port.v */
`timescale 1ns/1ps
`include "spim_regs.vh"
module spim_port (
   input wire aclk,
   input wire aresetn,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire sub_clock_freq,
   input wire timer_match,
   input wire sck_i,
   output wire sck_o,
   output wire sck_oe,
   input wire sdi_i,
   output wire sdo_o,
   output wire sdo_oe,
   input wire slave_select_n_i,
   output wire slave_select_n_o,
   output wire slave_select_n_oe,
   output wire spi_event
);
   localparam ST_IDLE = 3'b001;
   localparam ST_RUN = 3'b010;
   localparam ST_END = 3'b100;

   reg [7:0] mode_q;
   reg [7:0] ctrl_q;
   reg [7:0] buf_q;
   reg [2:0] st_q;
   reg [3:0] cnt_q;
   reg [5:0] div_q;
   reg sck_q;
   reg sdo_q;
   reg aw_q;
   reg w_q;
   reg [3:0] awa_q;
   reg [31:0] wd_q;
   reg [3:0] ws_q;
   reg sck_m_q;
   reg sck_s_q;
   reg sck_p_q;
   reg sdi_m_q;
   reg sdi_s_q;
   reg ss_m_q;
   reg ss_s_q;
   reg ss_p_q;
   reg sub_m_q;
   reg sub_s_q;
   reg sub_p_q;
   reg tm_m_q;
   reg tm_s_q;
   reg tm_p_q;
   reg tm_t_q;
   reg evt_q;
   reg cap_q;

   function first_bit;
      input [7:0] b;
      input msb;
      begin
         first_bit = msb ? b[7] : b[0];
      end
   endfunction

   function addr_hit;
      input [3:0] a;
      begin
         addr_hit = a == `SPIM_ADDR_MODE || a == `SPIM_ADDR_DATA || a == `SPIM_ADDR_CTRL;
      end
   endfunction

   wire [2:0] mode_select = mode_q[7:5];
   wire interface_enable = mode_q[`SPIM_BIT_EN];
   wire clock_idle_polarity = ctrl_q[`SPIM_BIT_POL];
   wire capture_edge_select = ctrl_q[`SPIM_BIT_EDGE];
   wire shift_order = ctrl_q[`SPIM_BIT_MLS];
   wire select_pin_enable = ctrl_q[`SPIM_BIT_SELECT_PIN_ENABLE];
   wire is_slave = mode_select == `SPIM_MODE_SLAVE;
   wire is_master = mode_select <= `SPIM_MODE_TMR;
   wire active = interface_enable && (is_master || is_slave);
   wire busy = !st_q[0];
   // polarity 0: idle high capture on second edge back to idle for edge=0
   wire idle_lvl = ~clock_idle_polarity;
   // capture edge is rising when (pol==0,edge==0) or (pol==1,edge==1)
   wire cap_rise = ~(clock_idle_polarity ^ capture_edge_select);
   wire out_bit = first_bit(buf_q, shift_order);

   function [7:0] shift_in;
      input [7:0] b;
      input msb;
      input d;
      begin
         shift_in = msb ? {b[6:0], d} : {d, b[7:1]};
      end
   endfunction

   // bus handshake
   wire wr_go = aw_q && w_q && !s_axi_bvalid;
   assign s_axi_awready = !aw_q && !s_axi_bvalid;
   assign s_axi_wready = !w_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire rd_go = s_axi_arvalid && !s_axi_rvalid;
   wire wr_mode = wr_go && awa_q == `SPIM_ADDR_MODE && ws_q[0];
   wire wr_data = wr_go && awa_q == `SPIM_ADDR_DATA && ws_q[0];
   wire wr_ctrl = wr_go && awa_q == `SPIM_ADDR_CTRL && ws_q[0];
   wire wr_ok = wr_data && active && !busy;
   wire wr_col = wr_data && busy;

   // master tick: half period of serial clock
   wire sub_rise = sub_s_q && !sub_p_q;
   wire tm_tick = tm_s_q && !tm_p_q;
   reg [5:0] half_lim;
   always @* begin
      case (mode_select)
         `SPIM_MODE_DIV4: half_lim = `SPIM_HALF_DIV4;
         `SPIM_MODE_DIV16: half_lim = `SPIM_HALF_DIV16;
         `SPIM_MODE_DIV64: half_lim = `SPIM_HALF_DIV64;
         default: half_lim = 6'd0;
      endcase
   end
   reg m_tick;
   always @* begin
      case (mode_select)
         `SPIM_MODE_SUB: m_tick = sub_rise;
         `SPIM_MODE_TMR: m_tick = tm_tick && tm_t_q;
         default: m_tick = div_q == half_lim;
      endcase
   end

   // slave edges from synchronised pin
   wire s_rise = sck_s_q && !sck_p_q;
   wire s_fall = !sck_s_q && sck_p_q;
   wire ss_rise = ss_s_q && !ss_p_q;
   wire sel_ok = !select_pin_enable || !ss_s_q;
   wire abort = is_slave && select_pin_enable && ss_rise && cnt_q != 4'd0;
   // serial clock edge events and whether each one captures
   wire m_edge = is_master && m_tick;
   wire s_edge = is_slave && sel_ok && (s_rise || s_fall);
   wire edge_ev = m_edge || s_edge;
   wire m_cap = (~sck_q) == cap_rise;
   wire s_cap = s_rise == cap_rise;
   wire edge_cap = is_master ? m_cap : s_cap;

   // pin synchronisers
   always @(posedge aclk) begin
      sck_m_q <= sck_i;
      sck_s_q <= sck_m_q;
      sck_p_q <= sck_s_q;
   end

   always @(posedge aclk) begin
      sdi_m_q <= sdi_i;
      sdi_s_q <= sdi_m_q;
   end

   always @(posedge aclk) begin
      ss_m_q <= slave_select_n_i;
      ss_s_q <= ss_m_q;
      ss_p_q <= ss_s_q;
   end

   always @(posedge aclk) begin
      sub_m_q <= sub_clock_freq;
      sub_s_q <= sub_m_q;
      sub_p_q <= sub_s_q;
   end

   always @(posedge aclk) begin
      tm_m_q <= timer_match;
      tm_s_q <= tm_m_q;
      tm_p_q <= tm_s_q;
   end

   // write channel: address and data taken in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awa_q <= 4'h0;
         wd_q <= 32'h0;
         ws_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SPIM_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awa_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_hit(awa_q) ? `SPIM_RESP_OKAY : `SPIM_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read channel: answer one cycle after the address
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `SPIM_RESP_OKAY;
         s_axi_rdata <= 32'h0;
      end else begin
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= addr_hit(s_axi_araddr) ? `SPIM_RESP_OKAY : `SPIM_RESP_SLVERR;
            case (s_axi_araddr)
               `SPIM_ADDR_MODE: s_axi_rdata <= {24'h0, mode_q};
               `SPIM_ADDR_DATA: s_axi_rdata <= {24'h0, buf_q};
               `SPIM_ADDR_CTRL: s_axi_rdata <= {24'h0, ctrl_q};
               default: s_axi_rdata <= 32'h0;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         mode_q <= `SPIM_MODE_RST;
         ctrl_q <= `SPIM_CTRL_RST;
         buf_q <= 8'h00;
         st_q <= ST_IDLE;
         cnt_q <= 4'h0;
         div_q <= 6'h00;
         sck_q <= 1'b1;
         sdo_q <= 1'b0;
         tm_t_q <= 1'b0;
         evt_q <= 1'b0;
         cap_q <= 1'b0;
      end else begin
         evt_q <= 1'b0;

         // control registers keep contents across enable changes mode bit 4 reads zero
         if (wr_mode) begin
            mode_q <= {wd_q[7:5], 1'b0, wd_q[3:2], wd_q[`SPIM_BIT_EN],
               wd_q[`SPIM_BIT_ICF] & mode_q[`SPIM_BIT_ICF]};
         end
         if (wr_ctrl) begin
            ctrl_q <= {wd_q[7:2], wd_q[`SPIM_BIT_WRITE_COLLISION_FLAG] & ctrl_q[`SPIM_BIT_WRITE_COLLISION_FLAG],
               wd_q[`SPIM_BIT_TRF] & ctrl_q[`SPIM_BIT_TRF]};
         end
         if (wr_col) begin
            ctrl_q[`SPIM_BIT_WRITE_COLLISION_FLAG] <= 1'b1;
         end

         if (m_tick || div_q == half_lim) begin
            div_q <= 6'h00;
         end else begin
            div_q <= div_q + 6'd1;
         end
         if (tm_tick) begin
            tm_t_q <= ~tm_t_q;
         end

         if (!active) begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            cap_q <= 1'b0;
            sck_q <= idle_lvl;
         end else if (abort) begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            cap_q <= 1'b0;
            mode_q[`SPIM_BIT_ICF] <= 1'b1;
            evt_q <= 1'b1;
         end else begin
            // capture lands a cycle late so the synchronised data pin has settled
            cap_q <= 1'b0;
            if (cap_q) begin
               buf_q <= shift_in(buf_q, shift_order, sdi_s_q);
            end
            case (st_q)
               ST_IDLE: begin
                  sck_q <= idle_lvl;
                  if (wr_ok) begin
                     buf_q <= wd_q[7:0];
                     sdo_q <= first_bit(wd_q[7:0], shift_order);
                     st_q <= ST_RUN;
                     cnt_q <= 4'h0;
                  end
               end
               ST_RUN: begin
                  if (edge_ev) begin
                     cnt_q <= cnt_q + 4'd1;
                     if (is_master) begin
                        sck_q <= ~sck_q;
                     end
                     if (edge_cap) begin
                        cap_q <= 1'b1;
                     end else if (cnt_q != 4'd0) begin
                        sdo_q <= out_bit;
                     end
                     if (cnt_q == `SPIM_LAST_EDGE) begin
                        st_q <= ST_END;
                     end
                  end
               end
               ST_END: begin
                  if (!cap_q) begin
                     st_q <= ST_IDLE;
                     cnt_q <= 4'h0;
                     ctrl_q[`SPIM_BIT_TRF] <= 1'b1;
                     evt_q <= 1'b1;
                  end
               end
               default: st_q <= ST_IDLE;
            endcase
         end
         if (wr_data && !active) begin
            buf_q <= wd_q[7:0];
            sdo_q <= first_bit(wd_q[7:0], shift_order);
         end
      end
   end

   assign sck_o = sck_q;
   assign sck_oe = active && is_master;
   assign sdo_o = sdo_q;
   assign sdo_oe = active && (is_master || sel_ok);
   assign slave_select_n_o = !busy ? 1'b1 : 1'b0;
   assign slave_select_n_oe = active && is_master && select_pin_enable;
   assign spi_event = evt_q;
endmodule // spim_port

/* verilog/spim_regs.vh */
`ifndef SPIM_REGS_VH
`define SPIM_REGS_VH
`define SPIM_ADDR_MODE 4'h0
`define SPIM_ADDR_DATA 4'h4
`define SPIM_ADDR_CTRL 4'h8
`define SPIM_MODE_RST 8'he0
`define SPIM_CTRL_RST 8'h00
`define SPIM_MODE_DIV4 3'b000
`define SPIM_MODE_DIV16 3'b001
`define SPIM_MODE_DIV64 3'b010
`define SPIM_MODE_SUB 3'b011
`define SPIM_MODE_TMR 3'b100
`define SPIM_MODE_SLAVE 3'b101
`define SPIM_BIT_EN 1
`define SPIM_BIT_ICF 0
`define SPIM_BIT_POL 5
`define SPIM_BIT_EDGE 4
`define SPIM_BIT_MLS 3
`define SPIM_BIT_SELECT_PIN_ENABLE 2
`define SPIM_BIT_WRITE_COLLISION_FLAG 1
`define SPIM_BIT_TRF 0
`define SPIM_HALF_DIV4 6'd1
`define SPIM_HALF_DIV16 6'd7
`define SPIM_HALF_DIV64 6'd31
`define SPIM_LAST_EDGE 4'hf
`define SPIM_RESP_OKAY 2'b00
`define SPIM_RESP_SLVERR 2'b10
`endif

/* sim/spim_assertions.sv */
`timescale 1ns/1ps
module spim_assertions (
   input logic aclk,
   input logic aresetn,
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic s_axi_bvalid,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic s_axi_rvalid,
   input logic [1:0] s_axi_rresp,
   input logic sck_o,
   input logic sck_oe,
   input logic sdo_oe,
   input logic slave_select_n_o,
   input logic slave_select_n_oe,
   input logic spi_event
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [4:0] tgl_q;
   // counts driven clock edges since the last event
   always @(posedge aclk) begin
      if (!aresetn || spi_event) tgl_q <= 5'h00;
      else if (sck_oe && $past(sck_oe) && $changed(sck_o)) tgl_q <= tgl_q + 5'h01;
   end
   evt_pulse_a: assert property (spi_event |=> !spi_event)
      else $error("event pulse too long");
   bit_count_a: assert property (spi_event && sck_oe |-> tgl_q == 5'd16)
      else $error("master byte not sixteen clock edges");
   sck_half_a: assert property (sck_oe && $changed(sck_o) |=> $stable(sck_o))
      else $error("clock half period under two cycles");
   sdo_master_a: assert property (sck_oe |-> sdo_oe)
      else $error("master not driving data out");
   sel_owner_a: assert property (slave_select_n_oe |-> sck_oe)
      else $error("select driven outside master mode");
   sel_frame_a: assert property (sck_oe && slave_select_n_oe && $changed(sck_o)
      |-> !slave_select_n_o)
      else $error("clock toggles while select high");
   rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   cover property (spi_event && sck_oe);
   cover property (spi_event && !sck_oe);
   cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // spim_assertions

/* sim/spim_peer.sv */
`timescale 1ns/1ps
module spim_peer (
   input wire sck,
   input wire en,
   input wire cap_rise,
   input wire msb,
   input wire [7:0] tx,
   input wire sdo,
   output wire sdi,
   output reg [7:0] rx
);
   reg [2:0] k_q = 3'h0;
   reg c_q = 1'b0;
   wire b = tx[msb ? 3'd7 - k_q : k_q];
   // released line shows the inverse of the bit
   assign sdi = en ? b : ~b;
   always @(posedge en) begin
      k_q <= 3'h0;
      c_q <= 1'b0;
   end
   always @(sck) begin
      if (sck == cap_rise) begin
         rx <= msb ? {rx[6:0], sdo} : {sdo, rx[7:1]};
         c_q <= 1'b1;
      end else if (c_q) k_q <= k_q + 3'h1;
   end
endmodule // spim_peer

/* sim/tb_spi_master_slave_port.sv */
`timescale 1ns/1ps
module tb_spi_master_slave_port;
   reg aclk = 0;
   reg aresetn = 0;
   reg [3:0] aw = 0, ar = 0;
   reg awv = 0, wv = 0, br = 0, arv = 0, rr = 0, sub = 0, tmr = 0;
   reg ck = 1, ss = 1, slv = 0, en = 0, cr = 0, ms = 0;
   reg [31:0] wd = 0;
   reg [7:0] tx = 0, d = 0, nev = 0;
   reg [2:0] sc = 0;
   reg [33:0] q[$];
   integer seed = 88, fails = 0, checks = 0, ne = 0, i, t;
   wire awr, wr, arr, bv, rv, sck_o, sck_oe, sdo, sdo_oe, sso, sso_oe, evt, sdi;
   wire [1:0] rresp, brsp;
   wire [31:0] rdat;
   wire [7:0] prx;
   spim_port i_spim_port (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(brsp), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .sub_clock_freq(sub), .timer_match(tmr), .sck_i(ck), .sck_o(sck_o), .sck_oe(sck_oe),
      .sdi_i(sdi), .sdo_o(sdo), .sdo_oe(sdo_oe), .slave_select_n_i(ss),
      .slave_select_n_o(sso), .slave_select_n_oe(sso_oe), .spi_event(evt));
   spim_peer i_spim_peer (.sck(slv ? ck : sck_o), .en(en), .cap_rise(cr), .msb(ms),
      .tx(tx), .sdo(sdo), .sdi(sdi), .rx(prx));
   always #20 aclk = ~aclk;
   task chk(input [33:0] g, input [33:0] e);
      begin
         checks = checks + 1;
         if (g !== e) begin
            fails = fails + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   always @(posedge aclk) begin
      sc <= sc + 3'h1;
      sub <= sc[2];
      tmr <= sc[1];
      if (evt) nev <= nev + 8'h1;
      if (rv && rr) chk({rresp, rdat}, q.pop_front());
   end
   task wreg(input [3:0] a, input [7:0] v);
      begin
         @(posedge aclk);
         aw <= a;
         wd <= {24'($random(seed)), v};
         awv <= 1;
         wv <= 1;
         br <= 1;
         fork
            begin
               @(negedge aclk);
               while (!awr) @(negedge aclk);
               @(posedge aclk);
               awv <= 0;
            end
            begin
               @(negedge aclk);
               while (!wr) @(negedge aclk);
               @(posedge aclk);
               wv <= 0;
            end
         join
         @(negedge aclk);
         while (!bv) @(negedge aclk);
         chk(34'(brsp), 34'h0);
         @(posedge aclk);
         br <= 0;
      end
   endtask
   task rreg(input [3:0] a, input [7:0] v, input [1:0] r);
      begin
         @(posedge aclk);
         ar <= a;
         arv <= 1;
         rr <= 1;
         q.push_back({r, 24'h0, v});
         @(negedge aclk);
         while (!arr) @(negedge aclk);
         @(posedge aclk);
         arv <= 0;
         @(negedge aclk);
         while (!rv) @(negedge aclk);
         @(posedge aclk);
         rr <= 0;
      end
   endtask
   task wev;
      begin
         ne = ne + 1;
         for (t = 0; t < 3000 && nev != ne; t = t + 1) @(posedge aclk);
         chk(34'(nev), 34'(ne));
      end
   endtask
   task xf(input [2:0] md, input [5:0] c, input col);
      begin
         wreg(4'h0, {md, 5'h00});
         wreg(4'h8, {c, 2'b00});
         wreg(4'h0, {md, 5'b01110});
         rreg(4'h8, {c, 2'b00}, 2'b00);
         chk(34'(sck_o), 34'(!c[3]));
         cr <= !(c[3] ^ c[2]);
         ms <= c[1];
         tx <= 8'($random(seed));
         d = 8'($random(seed));
         en <= 1;
         wreg(4'h4, d);
         if (col) wreg(4'h4, ~d);
         wev;
         en <= 0;
         rreg(4'h8, {c, col, 1'b1}, 2'b00);
         rreg(4'h4, tx, 2'b00);
         chk(34'(prx), 34'(d));
         wreg(4'h8, {c, 2'b00});
         $display("transfer mode %0d ctrl %h done", md, c);
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d fails %0d", checks, fails);
         if (fails == 0 && checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   initial begin
      #800000;
      fails = fails + 1;
      finish_test;
   end
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      rreg(4'h0, 8'he0, 2'b00);
      rreg(4'h8, 8'h00, 2'b00);
      rreg(4'hc, 8'h00, 2'b10);
      wreg(4'h0, 8'hff);
      rreg(4'h0, 8'hee, 2'b00);
      chk(34'({sck_oe, sdo_oe, sso_oe}), 34'h0);
      $display("register test done");
      for (i = 0; i < 8; i = i + 1)
         xf(3'h0, {2'($random(seed)), i[2:0], i[0] ^ i[2]}, i == 3);
      for (i = 1; i < 5; i = i + 1) xf(3'(i), 6'h03, 1'b0);
      wreg(4'h0, 8'h00);
      d = 8'($random(seed));
      wreg(4'h4, d);
      repeat (40) @(posedge aclk);
      chk(34'({sck_oe, sdo_oe, sso_oe}), 34'h0);
      rreg(4'h4, d, 2'b00);
      $display("disabled test done");
      slv <= 1;
      cr <= 0;
      ms <= 1;
      wreg(4'h8, 8'h1c);
      wreg(4'h0, 8'ha2);
      tx <= 8'($random(seed));
      d = 8'($random(seed));
      en <= 1;
      wreg(4'h4, d);
      ss <= 0;
      repeat (8) @(posedge aclk);
      repeat (16) begin repeat (6) @(posedge aclk); ck <= ~ck; end
      repeat (8) @(posedge aclk);
      ss <= 1;
      en <= 0;
      wev;
      rreg(4'h8, 8'h1d, 2'b00);
      rreg(4'h4, tx, 2'b00);
      chk(34'(prx), 34'(d));
      wreg(4'h4, d);
      ss <= 0;
      repeat (8) @(posedge aclk);
      repeat (4) begin repeat (6) @(posedge aclk); ck <= ~ck; end
      repeat (8) @(posedge aclk);
      ss <= 1;
      wev;
      rreg(4'h0, 8'ha3, 2'b00);
      $display("slave test done");
      finish_test;
   end
endmodule // tb_spi_master_slave_port
bind spim_port spim_assertions i_spim_assertions (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp), .sck_o(sck_o), .sck_oe(sck_oe),
   .sdo_oe(sdo_oe), .slave_select_n_o(slave_select_n_o),
   .slave_select_n_oe(slave_select_n_oe), .spi_event(spi_event));
